// ==== src/cfg_host_pkg.sv ====
// Package with register map, field positions and timing constants of the configuration host.
//
// Notes on behaviour
// - Clocks per 32-bit word: 1 plain, 4 encrypted, 8 when compressed.
// - Host gives ratio clock cycles with every data word.
// - With ratio above one, host stops clock only ratio minus 1 cycles after last word.
// - In user mode all three lines are high; request low starts reconfiguration.
// - After configuration the host keeps driving the configuration clock.
// - Host pauses by holding clock low; data is valid before next rising edge.
// - Host sends whole image; load complete rises only after all data arrives.
// - After load complete rises host gives two more falling clock edges.
// - Host holds the request low at least 2 us.
// - Host waits 2 us after status rises, or 1506 us after request rises.
// - Clock at most 125 MHz for 8, 16 and serial, 100 MHz for 32-bit.
// - Host holds each word ratio minus 1 clock periods after its latching edge.
// - User start-up clock enabled four clock periods after load complete, then 8576 cycles; the host has no user start-up clock.
package cfg_host_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS   = 8'h08;
  localparam logic [7:0] COUNT_OFS  = 8'h0c;

  // Control register fields.
  localparam int unsigned CTRL_START  = 0;
  localparam int unsigned CTRL_WIDTH0 = 1;
  localparam int unsigned CTRL_WIDTH1 = 2;
  localparam int unsigned CTRL_ENC    = 3;
  localparam int unsigned CTRL_COMP   = 4;
  localparam int unsigned CTRL_MONST  = 5;
  localparam int unsigned CTRL_ABORT  = 6;
  localparam int unsigned CTRL_FINISH = 7;
  localparam int unsigned CTRL_DIV0   = 8;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0022;

  // Status register fields.
  localparam int unsigned ST_BUSY     = 0;
  localparam int unsigned ST_WREADY   = 1;
  localparam int unsigned ST_DONE     = 2;
  localparam int unsigned ST_ERROR    = 3;
  localparam int unsigned ST_PIN_ST   = 4;
  localparam int unsigned ST_PIN_LC   = 5;
  localparam int unsigned ST_STATE0   = 8;

  // Width codes in the control register.
  localparam logic [1:0] W_SERIAL = 2'h0;
  localparam logic [1:0] W_8      = 2'h1;
  localparam logic [1:0] W_16     = 2'h2;
  localparam logic [1:0] W_32     = 2'h3;

  // Clock-to-data ratios.
  localparam logic [3:0] RATIO_PLAIN = 4'h1;
  localparam logic [3:0] RATIO_ENC   = 4'h4;
  localparam logic [3:0] RATIO_COMP  = 4'h8;

  // Timing in the unit printed and derived cycle counts.
  localparam int unsigned T_REQ_LOW_US   = 2;
  localparam int unsigned T_ST2CK_US     = 2;
  localparam int unsigned T_CF2CK_US     = 1506;
  localparam int unsigned REQ_LOW_CYC    = T_REQ_LOW_US * CLK_MHZ;
  localparam int unsigned ST2CK_CYC      = T_ST2CK_US * CLK_MHZ;
  localparam int unsigned CF2CK_CYC      = T_CF2CK_US * CLK_MHZ;
  localparam int unsigned FINAL_FALLS    = 2;
  localparam logic [7:0]  DIV_MIN_32     = 8'h01;

  // Controller states.
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_REQ   = 3'b001,
    S_WAIT  = 3'b010,
    S_LOAD  = 3'b011,
    S_TAIL  = 3'b100,
    S_INIT  = 3'b101,
    S_DONE  = 3'b110,
    S_ERR   = 3'b111
  } state_e;

endpackage

// ==== src/cfg_clock_gen.sv ====
// Divider that makes the configuration clock and marks its rising and falling edges.
`timescale 1ns/100ps
`default_nettype none
module cfg_clock_gen (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [7:0] half_period,
  output logic            cclk,
  output logic            rise,
  output logic            fall
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       cclk_r;
  logic       wrap;

  // Half-period counter; the clock only rises while running but always falls, so it parks low.
  assign wrap    = (cnt_r >= half_period);
  assign cnt_nxt = wrap ? 8'h00 : cnt_r + 8'h01;
  assign rise    = run && wrap && !cclk_r;
  assign fall    = wrap && cclk_r;
  assign cclk    = cclk_r;

  // The clock finishes its high phase even when stopped, so it never rests high.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r  <= 8'h00;
      cclk_r <= 1'b0;
    end else if (run || cclk_r) begin
      cnt_r <= cnt_nxt;
      if (rise || fall) begin
        cclk_r <= !cclk_r;
      end
    end else begin
      cnt_r <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ==== src/cfg_host.sv ====
// Configuration host: APB registers on one side, configuration pins of the device on the other.
`timescale 1ns/100ps
`default_nettype none
module cfg_host #(
  parameter int unsigned REQ_LOW_CYC = cfg_host_pkg::REQ_LOW_CYC,
  parameter int unsigned ST2CK_CYC   = cfg_host_pkg::ST2CK_CYC,
  parameter int unsigned CF2CK_CYC   = cfg_host_pkg::CF2CK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             config_request_n,
  input  wire logic        config_status_n,
  input  wire logic        load_complete,
  output logic             config_clock,
  output logic      [31:0] config_data
);

  // Pin synchronisers.
  logic        st_s1_r;
  logic        st_s2_r;
  logic        lc_s1_r;
  logic        lc_s2_r;

  // Registers and state.
  logic [31:0] ctrl_r;
  logic [31:0] word_r;
  logic        word_full_r;
  logic        pres_r;
  logic [31:0] words_r;
  logic [31:0] wait_r;
  logic [3:0]  beat_r;
  logic [4:0]  shift_r;
  logic        error_r;
  logic        done_r;
  logic        req_n_r;
  logic [31:0] data_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  cfg_host_pkg::state_e state_r;
  cfg_host_pkg::state_e state_nxt;

  // Decoded fields and bus strobes.
  wire [1:0] width   = {ctrl_r[cfg_host_pkg::CTRL_WIDTH1], ctrl_r[cfg_host_pkg::CTRL_WIDTH0]};
  wire       enc     = ctrl_r[cfg_host_pkg::CTRL_ENC];
  wire       comp    = ctrl_r[cfg_host_pkg::CTRL_COMP];
  wire       monst   = ctrl_r[cfg_host_pkg::CTRL_MONST];
  wire       finish  = ctrl_r[cfg_host_pkg::CTRL_FINISH];
  wire [7:0] div_raw = ctrl_r[cfg_host_pkg::CTRL_DIV0 +: 8];
  wire       acc     = psel && penable && !pready_r;
  wire       wr      = acc && pwrite;
  wire       wr_ctrl = wr && (paddr == cfg_host_pkg::CTRL_OFS);
  wire       wr_data = wr && (paddr == cfg_host_pkg::DATA_OFS);
  wire       mapped  = (paddr == cfg_host_pkg::CTRL_OFS) || (paddr == cfg_host_pkg::STATUS_OFS)
                    || (paddr == cfg_host_pkg::DATA_OFS) || (paddr == cfg_host_pkg::COUNT_OFS);
  wire       start   = wr_ctrl && pwdata[cfg_host_pkg::CTRL_START];
  wire       abort   = wr_ctrl && pwdata[cfg_host_pkg::CTRL_ABORT];

  // Ratio of clocks per word and index of the last piece of a loaded word.
  function automatic logic [3:0] ratio_of(input logic e, input logic c);
    ratio_of = c ? cfg_host_pkg::RATIO_COMP : (e ? cfg_host_pkg::RATIO_ENC
                                                  : cfg_host_pkg::RATIO_PLAIN);
  endfunction
  wire [3:0] ratio = ratio_of(enc, comp);
  wire [4:0] beats = (width == cfg_host_pkg::W_SERIAL) ? 5'h1f :
                     (width == cfg_host_pkg::W_8) ? 5'h03 :
                     (width == cfg_host_pkg::W_16) ? 5'h01 : 5'h00;
  // 32-bit loading may not exceed 100 MHz, so the divider never goes below one.
  wire [7:0] div = (width == cfg_host_pkg::W_32 && div_raw < cfg_host_pkg::DIV_MIN_32)
                   ? cfg_host_pkg::DIV_MIN_32 : div_raw;

  // Configuration clock generator.
  logic run, rise, fall, cclk;
  // While loading, the clock only runs once a word stands on the data pins, so no rising edge meets changing data.
  assign run = (state_r == cfg_host_pkg::S_LOAD && pres_r) || state_r == cfg_host_pkg::S_TAIL
               || state_r == cfg_host_pkg::S_INIT;
  cfg_clock_gen u_clk (
    .clk         (clk),
    .rstn        (rstn),
    .run         (run),
    .half_period (div),
    .cclk        (cclk),
    .rise        (rise),
    .fall        (fall)
  );

  wire status_low = !st_s2_r;
  wire lc_high    = lc_s2_r;
  wire wait_done  = (wait_r == 32'h0);
  wire last_beat  = (beat_r + 4'h1 >= ratio);
  wire word_end   = rise && last_beat && shift_r == 5'h00 && state_r == cfg_host_pkg::S_LOAD;
  wire word_first = rise && beat_r == 4'h0 && shift_r == 5'h00;
  // Start of a fresh request, and the falling edge that hands out the next narrow piece.
  wire enter_req  = (state_nxt == cfg_host_pkg::S_REQ) && (state_r != cfg_host_pkg::S_REQ);
  wire piece_next = fall && state_r == cfg_host_pkg::S_LOAD && beat_r == 4'h0
                    && shift_r != 5'h00;

  // Next-state decode.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cfg_host_pkg::S_IDLE: if (start) state_nxt = cfg_host_pkg::S_REQ;
      cfg_host_pkg::S_REQ:  if (wait_done) state_nxt = cfg_host_pkg::S_WAIT;
      cfg_host_pkg::S_WAIT: if (wait_done && (!monst || !status_low))
                              state_nxt = cfg_host_pkg::S_LOAD;
      cfg_host_pkg::S_LOAD: if (status_low) state_nxt = cfg_host_pkg::S_ERR;
                            else if (finish && !word_full_r && beat_r == 4'h0
                                     && shift_r == 5'h00)
                              state_nxt = cfg_host_pkg::S_TAIL;
      cfg_host_pkg::S_TAIL: if (status_low) state_nxt = cfg_host_pkg::S_ERR;
                            else if (lc_high) state_nxt = cfg_host_pkg::S_INIT;
      cfg_host_pkg::S_INIT: if (wait_r >= cfg_host_pkg::FINAL_FALLS)
                              state_nxt = cfg_host_pkg::S_DONE;
      cfg_host_pkg::S_DONE: if (start) state_nxt = cfg_host_pkg::S_REQ;
      cfg_host_pkg::S_ERR:  if (start) state_nxt = cfg_host_pkg::S_REQ;
      default:              state_nxt = cfg_host_pkg::S_IDLE;
    endcase
    // An abort never cuts the request pulse short; it is dropped while the pulse runs.
    if (abort && state_r != cfg_host_pkg::S_REQ) state_nxt = cfg_host_pkg::S_IDLE;
  end

  // Two-flop synchronisers on the device's status and load-complete pins.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_s1_r <= 1'b1;
      st_s2_r <= 1'b1;
      lc_s1_r <= 1'b0;
      lc_s2_r <= 1'b0;
    end else begin
      st_s1_r <= config_status_n;
      st_s2_r <= st_s1_r;
      lc_s1_r <= load_complete;
      lc_s2_r <= lc_s1_r;
    end
  end

  // State, request pin and wait counter.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= cfg_host_pkg::S_IDLE;
      req_n_r <= 1'b1;
      wait_r  <= 32'h0;
    end else begin
      state_r <= state_nxt;
      req_n_r <= (state_nxt != cfg_host_pkg::S_REQ);
      if (state_nxt != state_r) begin
        if (state_nxt == cfg_host_pkg::S_REQ)
          wait_r <= 32'(REQ_LOW_CYC - 1);
        else if (state_nxt == cfg_host_pkg::S_WAIT)
          wait_r <= monst ? 32'(ST2CK_CYC) : 32'(CF2CK_CYC);
        else
          wait_r <= 32'h0;
      end else if (state_r == cfg_host_pkg::S_WAIT && monst && status_low) begin
        wait_r <= 32'(ST2CK_CYC);
      end else if (state_r == cfg_host_pkg::S_INIT) begin
        if (fall) wait_r <= wait_r + 32'h1;
      end else if (!wait_done) begin
        wait_r <= wait_r - 32'h1;
      end
    end
  end

  // Word holding register, beat counter and shift position; data stays put between words.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      word_r      <= 32'h0;
      word_full_r <= 1'b0;
      pres_r      <= 1'b0;
      beat_r      <= 4'h0;
      shift_r     <= 5'h00;
      data_r      <= 32'h0;
      words_r     <= 32'h0;
    end else begin
      if (state_r == cfg_host_pkg::S_REQ) words_r <= 32'h0;
      if (wr_data && !word_full_r) begin
        word_r      <= pwdata;
        word_full_r <= 1'b1;
      end
      // Data goes out while the clock is low, at least a cycle before the edge that latches it.
      if (state_r == cfg_host_pkg::S_LOAD && word_full_r && !pres_r && !cclk) begin
        data_r <= word_r;
        pres_r <= 1'b1;
      end
      // A narrow word moves on at the falling edge after its piece got all its beats.
      if (piece_next) begin
        data_r <= (width == cfg_host_pkg::W_SERIAL) ? {1'b0, data_r[31:1]} :
                  (width == cfg_host_pkg::W_8) ? {8'h00, data_r[31:8]} :
                  {16'h0000, data_r[31:16]};
      end
      if (rise && state_r == cfg_host_pkg::S_LOAD && pres_r) begin
        if (word_first) words_r <= words_r + 32'h1;
        if (last_beat) begin
          beat_r <= 4'h0;
          if (shift_r == beats) begin
            shift_r     <= 5'h00;
            word_full_r <= 1'b0;
            pres_r      <= 1'b0;
          end else begin
            shift_r <= shift_r + 5'h01;
          end
        end else begin
          beat_r <= beat_r + 4'h1;
        end
      end
      // A new request starts from an empty slot, so a cut load leaves nothing behind.
      if (enter_req) begin
        word_full_r <= 1'b0;
        pres_r      <= 1'b0;
        beat_r      <= 4'h0;
        shift_r     <= 5'h00;
      end
    end
  end

  // Control register and sticky result flags; a set beats a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r  <= cfg_host_pkg::CTRL_RST;
      error_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= pwdata & ~32'h0000_0041;
      if (state_nxt == cfg_host_pkg::S_ERR && state_r != cfg_host_pkg::S_ERR)
        error_r <= 1'b1;
      else if (start) error_r <= 1'b0;
      if (state_nxt == cfg_host_pkg::S_DONE) done_r <= 1'b1;
      else if (start) done_r <= 1'b0;
    end
  end

  // APB slave: one wait state, unmapped addresses answer with an error.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= acc;
      pslverr_r <= acc && (!mapped || (wr_data && word_full_r));
      if (acc && !pwrite) begin
        case (paddr)
          cfg_host_pkg::CTRL_OFS:   prdata_r <= ctrl_r;
          cfg_host_pkg::STATUS_OFS: prdata_r <= {21'h0, state_r, 2'h0, lc_s2_r, st_s2_r,
                                                 error_r, done_r, !word_full_r,
                                                 state_r != cfg_host_pkg::S_IDLE
                                                 && state_r != cfg_host_pkg::S_DONE
                                                 && state_r != cfg_host_pkg::S_ERR};
          cfg_host_pkg::COUNT_OFS:  prdata_r <= words_r;
          default:                  prdata_r <= 32'h0;
        endcase
      end else begin
        prdata_r <= 32'h0;
      end
    end
  end

  // Outputs straight from flip-flops; the clock is always driven, low when idle.
  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign config_request_n = req_n_r;
  assign config_clock     = cclk;
  assign config_data      = data_r;

endmodule
`default_nettype wire

// ==== test/cfg_host_checker.sv ====
// Checker of bus and pin timing at the configuration host's ports.
`timescale 1ns/100ps
`default_nettype none
module cfg_host_checker #(
  parameter int unsigned REQ_LOW_CYC = 8,
  parameter int unsigned ST2CK_CYC   = 8
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        config_request_n,
  input wire logic        config_status_n,
  input wire logic        load_complete,
  input wire logic        config_clock,
  input wire logic [31:0] config_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [15:0] req_lo_r;
  logic [15:0] st_hi_r;
  // Saturating counts of cycles with request low and with status high.
  always_ff @(posedge clk) begin
    if (!rstn || config_request_n) req_lo_r <= 16'h0000;
    else if (req_lo_r != 16'hffff) req_lo_r <= req_lo_r + 16'h0001;
    if (!rstn || !config_status_n) st_hi_r <= 16'h0000;
    else if (st_hi_r != 16'hffff) st_hi_r <= st_hi_r + 16'h0001;
  end
  // Steps of a bus transfer and of a lost status line.
  sequence apb_setup; psel && !penable; endsequence
  sequence apb_access; psel && penable; endsequence
  sequence status_lost; (config_request_n && !config_status_n) [*8]; endsequence
  chk_req_width: assert property ($rose(config_request_n) |-> req_lo_r >= REQ_LOW_CYC)
    else $error("request low pulse too short");
  chk_clk_quiet: assert property (!config_request_n |-> !config_clock)
    else $error("clock runs while request is low");
  chk_first_edge: assert property ($rose(config_clock) |-> st_hi_r >= ST2CK_CYC)
    else $error("clock edge too soon after status rose");
  chk_data_hold: assert property (config_clock |-> $stable(config_data))
    else $error("data changed while clock high");
  chk_err_halt: assert property (status_lost |-> !config_clock)
    else $error("clock still runs with status low");
  chk_apb_answer: assert property (apb_setup ##1 apb_access |=> pready)
    else $error("bus answer late");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  cover property ($rose(load_complete));
endmodule
bind cfg_host cfg_host_checker #(.REQ_LOW_CYC(REQ_LOW_CYC), .ST2CK_CYC(ST2CK_CYC)) u_chk (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .config_request_n(config_request_n), .config_status_n(config_status_n),
  .load_complete(load_complete), .config_clock(config_clock), .config_data(config_data));
`default_nettype wire

// ==== test/cfg_dev_model.sv ====
// Behavioural model of the programmable device's configuration pins.
`timescale 1ns/100ps
`default_nettype none
module cfg_dev_model #(
  parameter int unsigned STAT_LOW_CYC = 20,
  parameter int unsigned INIT_CYC     = 40
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        config_request_n,
  input wire logic        config_clock,
  input wire logic [31:0] config_data,
  input wire logic [15:0] img_rises,
  input wire logic        force_err,
  output logic            config_status_n,
  output logic            load_complete,
  output logic            init_done,
  output logic            user_mode
);
  logic [31:0] log_r [64];
  logic [15:0] rises_r, gap_r, first_gap_r;
  logic [7:0]  hold_r, init_r;
  logic [1:0]  falls_r;
  logic        ck_r, st_r, lc_r, user_r, got_r;
  wire logic   rise_w = config_clock & ~ck_r;
  wire logic   fall_w = ~config_clock & ck_r;
  // Pin drive; initialization-complete stays low until user mode.
  assign config_status_n = st_r;
  assign load_complete   = lc_r;
  assign init_done       = user_r;
  assign user_mode       = user_r;
  // Request low clears the pins and counters at once, well inside 600 ns; the data log is kept.
  always_ff @(posedge clk) begin
    ck_r <= config_clock;
    if (!rstn || !config_request_n) begin
      {st_r, lc_r, user_r, got_r} <= 4'h0;
      {rises_r, gap_r} <= 32'h0;
      {hold_r, init_r, falls_r} <= 18'h0;
    end else begin
      if (gap_r != 16'hffff) gap_r <= gap_r + 16'h0001;
      if (hold_r < STAT_LOW_CYC) hold_r <= hold_r + 8'h01;
      st_r <= !force_err && (hold_r >= STAT_LOW_CYC);
      if (rise_w && !lc_r) begin
        log_r[rises_r[5:0]] <= config_data;
        rises_r <= rises_r + 16'h0001;
        lc_r <= (rises_r + 16'h0001 == img_rises);
        got_r <= 1'b1;
        if (!got_r) first_gap_r <= gap_r;
      end
      if (lc_r && fall_w && falls_r != 2'h3) falls_r <= falls_r + 2'h1;
      if (falls_r >= 2'h2 && !user_r) begin
        if (init_r == INIT_CYC) user_r <= 1'b1;
        else init_r <= init_r + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/cfg_host_test.sv ====
// Self-checking bench of the configuration host against the device model.
`timescale 1ns/100ps
`default_nettype none
module cfg_host_test;
  localparam int unsigned CF2CK = 60;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        force_err = 1'b0;
  logic [15:0] img_rises = 16'h0001;
  wire logic [31:0] prdata, config_data;
  wire logic   pready, pslverr, config_request_n, config_status_n;
  wire logic   load_complete, config_clock, init_done, user_mode;
  int          n_fail = 0;
  int          n_compared = 0;
  logic [31:0] q;
  logic        e;
  // Clock of 100 MHz.
  always #5 clk = ~clk;
  cfg_host #(.REQ_LOW_CYC(8), .ST2CK_CYC(8), .CF2CK_CYC(CF2CK)) DUT (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_request_n(config_request_n), .config_status_n(config_status_n),
    .load_complete(load_complete), .config_clock(config_clock), .config_data(config_data));
  cfg_dev_model dev (
    .clk(clk), .rstn(rstn), .config_request_n(config_request_n), .config_clock(config_clock),
    .config_data(config_data), .img_rises(img_rises), .force_err(force_err),
    .config_status_n(config_status_n), .load_complete(load_complete),
    .init_done(init_done), .user_mode(user_mode));
  function automatic logic [31:0] word(input int k);
    word = 32'h5ac3_96e1 + 32'(k) * 32'h0123_4567;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus transfer, held until ready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) n_fail++;
  endtask
  task automatic poll(input int bit_i, input logic val);
    int i;
    for (i = 0; i < 3000; i++) begin
      apb(1'b0, cfg_host_pkg::STATUS_OFS, 32'h0);
      if (q[bit_i] === val) break;
    end
    check(32'(i < 3000), 32'h1);
  endtask
  // Full load in one mode, then the wire trace is compared beat by beat.
  task automatic run_load(input logic [1:0] w, input logic enc, input logic comp,
                          input logic mon, input int nw);
    int ratio, beats, wb, b;
    logic [31:0] ctrl, m;
    ratio = comp ? 8 : (enc ? 4 : 1);
    beats = (w == 2'h3) ? 1 : (w == 2'h2) ? 2 : (w == 2'h1) ? 4 : 32;
    wb = 32 / beats;
    m = (wb == 32) ? 32'hffff_ffff : ((32'h1 << wb) - 32'h1);
    img_rises <= 16'(nw * beats * ratio);
    ctrl = {16'h0000, (w == 2'h0) ? 8'h00 : 8'h03, 2'b00, mon, comp, enc, w, 1'b0};
    apb(1'b1, cfg_host_pkg::CTRL_OFS, ctrl | 32'h1);
    for (int k = 0; k < nw; k++) begin
      poll(cfg_host_pkg::ST_WREADY, 1'b1);
      apb(1'b1, cfg_host_pkg::DATA_OFS, word(k));
      check(32'(e), 32'h0);
    end
    apb(1'b1, cfg_host_pkg::CTRL_OFS, ctrl | 32'h80);
    poll(cfg_host_pkg::ST_DONE, 1'b1);
    for (int i = 0; i < 2000 && user_mode !== 1'b1; i++) @(posedge clk);
    check({29'h0, config_request_n, config_status_n, load_complete}, 32'h7);
    check(32'(dev.falls_r >= 2'h2), 32'h1);
    check({31'h0, config_clock}, 32'h0);
    apb(1'b0, cfg_host_pkg::COUNT_OFS, 32'h0);
    check(q, 32'(nw));
    for (int i = 0; i < nw * beats * ratio; i++) begin
      b = i / ratio;
      check(dev.log_r[i] & m, (word(b / beats) >> ((b % beats) * wb)) & m);
    end
    if (!mon) check(32'(dev.first_gap_r >= 16'(CF2CK)), 32'h1);
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    test_done;
  end
  // Reset values, a lost status in mid-load, then every ratio and width.
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, cfg_host_pkg::CTRL_OFS, 32'h0);
    check(q, cfg_host_pkg::CTRL_RST);
    apb(1'b0, cfg_host_pkg::COUNT_OFS, 32'h0);
    check(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(32'(e), 32'h1);
    img_rises <= 16'd100;
    apb(1'b1, cfg_host_pkg::CTRL_OFS, 32'h0000_0337);
    poll(cfg_host_pkg::ST_WREADY, 1'b1);
    apb(1'b1, cfg_host_pkg::DATA_OFS, word(0));
    for (int i = 0; i < 2000 && dev.rises_r < 16'h2; i++) @(posedge clk);
    force_err <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b0, cfg_host_pkg::STATUS_OFS, 32'h0);
    check(32'(q[cfg_host_pkg::ST_ERROR]), 32'h1);
    check({30'h0, config_request_n, config_clock}, 32'h2);
    force_err <= 1'b0;
    // An abort while waiting after the request pulse returns the host to idle.
    apb(1'b1, cfg_host_pkg::CTRL_OFS, 32'h0000_0307);
    repeat (12) @(posedge clk);
    apb(1'b1, cfg_host_pkg::CTRL_OFS, 32'h0000_0346);
    apb(1'b0, cfg_host_pkg::STATUS_OFS, 32'h0);
    check({21'h0, q[10:8], 7'h0, q[0]}, 32'h0);
    check({30'h0, config_request_n, config_clock}, 32'h2);
    for (int md = 0; md < 4; md++) run_load(2'h3, md[0], md[1], md != 3, 2);
    run_load(2'h1, 1'b0, 1'b0, 1'b1, 1);
    run_load(2'h2, 1'b1, 1'b0, 1'b1, 1);
    run_load(2'h0, 1'b0, 1'b0, 1'b1, 1);
    test_done;
  end
endmodule
`default_nettype wire
